/* File: design/hdc_channel.sv */
// Purpose: hdlc channel control, bit-serial engines and apb registers
// Assumes: strobes mark framer overhead bit slots, one per core clock
// Notes:   crc bytes are held back three deep so they never reach the fifo
//
// What this block does
// [RULE1] append 16-bit crc unless crc defeat set
// [RULE2] crc invert flips all crc bits
// [RULE3] zero stuffing between flags unless defeated
// [RULE4] fill with 7Eh or FFh per fill_select
// [RULE5] transmit invert flips whole outgoing stream
// [RULE6] receive invert flips whole incoming stream
// [RULE7] tx reset rise flushes, aborts, then fills
// [RULE8] rx reset rise flushes and hunts again
// [RULE9] tx low mark code picks 16..240 bytes
// [RULE10] tx below mark while fifo under threshold
// [RULE11] rx high mark code picks 16..240 bytes
// [RULE12] rx above mark while fifo over threshold
// [RULE13] latched flags sticky, w1c, gated interrupt
// [RULE14] tag opening, closing, status; drop crc bytes
// [RULE15] message end appends crc and closing flag
// [RULE16] reset bits stored, only rising write acts
`timescale 1ns/100ps
`default_nettype none
module hdc_channel (
  input  wire logic                       core_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [hdc_pkg::APB_AW-1:0] paddr,
  input  wire logic [hdc_pkg::APB_DW-1:0] pwdata,
  output logic      [hdc_pkg::APB_DW-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic                            hdlc_irq,
  input  wire logic                       tx_bit_strobe,
  output logic                            tx_bit_out,
  input  wire logic                       rx_bit_strobe,
  input  wire logic                       rx_bit_in
);
  import hdc_pkg::*;

  typedef struct packed {
    logic [7:0]          ctrl;
    logic [7:0]          wmsel;
    logic [7:0]          lat;
    logic [7:0]          ie;
    logic                blk_en;
    logic                mend_pend;
    logic [APB_DW-1:0]   prdata;
    logic                pready;
    logic                pslverr;
    logic                irq;
    logic                tlow_d;
    logic                rhigh_d;
    hdc_tx_state_t       tst;
    logic [15:0]         tsh;
    logic [4:0]          tleft;
    logic [2:0]          tones;
    logic [15:0]         tcrc;
    logic                tx_message_end_tag;
    logic                tbit;
    logic                rin;
    logic                rfirst;
    logic                rlock;
    logic [2:0]          rones;
    logic [7:0]          rsh;
    logic [2:0]          rbits;
    logic [1:0]          rheld;
    logic [7:0]          h0;
    logic [7:0]          h1;
    logic [7:0]          h2;
    logic [15:0]         rcrc;
  } hdc_st_t;

  hdc_st_t            s;
  hdc_st_t            next_s;
  logic               tx_push;
  logic               tx_pop;
  logic               tx_flush;
  logic [TX_W-1:0]    tx_rdata;
  logic [FIFO_AW:0]   tx_count;
  logic               tx_empty;
  logic               rx_push;
  logic               rx_pop;
  logic               rx_flush;
  logic [RX_W-1:0]    rx_wdata;
  logic [RX_W-1:0]    rx_rdata;
  logic [FIFO_AW:0]   rx_count;
  logic               rx_empty;
  logic               rx_full;
  logic               tx_low;
  logic               rx_high;
  logic [7:0]         ev;
  logic               acc;
  logic               wr;
  logic               wr_ctrl;
  logic               tx_stuff;
  logic               tx_step;
  logic               t_end;
  logic [15:0]        tx_fcs;
  logic               rb;

  hdc_fifo #(.W(TX_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_tx_fifo (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .flush    (tx_flush),
    .push     (tx_push),
    .wdata    ({s.mend_pend, pwdata[7:0]}),
    .pop      (tx_pop),
    .rdata    (tx_rdata),
    .count    (tx_count),
    .empty    (tx_empty),
    .full     ()
  );

  hdc_fifo #(.W(RX_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_rx_fifo (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .flush    (rx_flush),
    .push     (rx_push),
    .wdata    (rx_wdata),
    .pop      (rx_pop),
    .rdata    (rx_rdata),
    .count    (rx_count),
    .empty    (rx_empty),
    .full     (rx_full)
  );

  // bus decode, watermarks and tx step qualifiers
  always_comb begin
    acc      = psel & penable & s.pready;
    wr       = acc & pwrite & (paddr[1:0] == 2'h0);
    wr_ctrl  = wr & (paddr[11:2] == IDX_CTRL_ONE);
    tx_flush = wr_ctrl & pwdata[CTL_TX_RST] & ~s.ctrl[CTL_TX_RST]; // see [RULE16]
    rx_flush = wr_ctrl & pwdata[CTL_RX_RST] & ~s.ctrl[CTL_RX_RST]; // see [RULE16]
    tx_low   = tx_count < hdc_thr(s.wmsel[2:0]);  // see [RULE9] see [RULE10]
    rx_high  = rx_count > hdc_thr(s.wmsel[6:4]);  // see [RULE11] see [RULE12]
    // five ones that end the crc still get a stuffed zero before the flag
    tx_stuff = ~s.ctrl[CTL_ZS_DEFEAT] & (s.tones == ONES_STUFF) // see [RULE3]
               & ((s.tst == TX_DATA) | (s.tst == TX_CRC)
                  | ((s.tst == TX_CLOSE) & (s.tleft == BYTE_BITS)));
    tx_step  = tx_bit_strobe & ~tx_flush & ~tx_stuff;
    t_end    = tx_step & (s.tleft == 5'h01);
    rb       = rx_bit_in ^ s.ctrl[CTL_RX_INV];    // see [RULE6]
  end

  // whole next-state computation
  always_comb begin
    logic       tb;
    logic       rx_do;
    logic [7:0] rbyte;
    tb       = 1'b0;
    rx_do    = 1'b0;
    rbyte    = 8'h00;
    next_s   = s;
    tx_push  = 1'b0;
    tx_pop   = 1'b0;
    rx_push  = 1'b0;
    rx_pop   = 1'b0;
    rx_wdata = '0;
    ev       = 8'h00;
    tx_fcs   = 16'h0000;

    // apb setup cycle: answer is prepared for the access phase
    next_s.pready = psel & ~penable;
    if (psel & ~penable) begin
      next_s.prdata  = '0;
      next_s.pslverr = (paddr[1:0] != 2'h0);
      case (paddr[11:2])
        IDX_CTRL_ONE: next_s.prdata[7:0] = s.ctrl;
        IDX_WM_SEL:   next_s.prdata[7:0] = s.wmsel & WM_MASK;
        IDX_LIVE: begin
          next_s.prdata[LIVE_TLOW]  = tx_low;
          next_s.prdata[LIVE_RHIGH] = rx_high;
        end
        IDX_LATCHED:  next_s.prdata[7:0] = s.lat;
        IDX_IRQ_EN:   next_s.prdata[7:0] = s.ie;
        IDX_BLK_EN:   next_s.prdata[0]   = s.blk_en;
        IDX_INFO: begin
          next_s.prdata[INFO_RX_FIFO_EMPTY] = rx_empty;
          next_s.prdata[INFO_TX_FIFO_EMPTY] = tx_empty;
          next_s.prdata[3:0] = tx_count[FIFO_AW] ? 4'hf : tx_count[7:4];
        end
        IDX_RX_DATA:  next_s.prdata[7:0] = rx_rdata[7:0];
        IDX_RX_TAG:   next_s.prdata[3:0] = rx_rdata[11:8];
        IDX_TX_DATA, IDX_TX_TAG: next_s.prdata = '0;
        default:      next_s.pslverr = 1'b1;
      endcase
    end

    // register writes; reset bits are kept exactly as written
    if (wr) begin
      unique case (paddr[11:2])
        IDX_CTRL_ONE: next_s.ctrl  = pwdata[7:0];  // see [RULE16]
        IDX_WM_SEL:   next_s.wmsel = pwdata[7:0] & WM_MASK;
        IDX_IRQ_EN:   next_s.ie    = pwdata[7:0];
        IDX_BLK_EN:   next_s.blk_en = pwdata[0];
        IDX_TX_TAG:   next_s.mend_pend = pwdata[0];
        IDX_TX_DATA: begin
          tx_push = 1'b1;
          next_s.mend_pend = 1'b0;
        end
        default: ;
      endcase
    end
    if (acc & ~pwrite & (paddr == {IDX_RX_DATA, 2'h0})) begin
      rx_pop = 1'b1;
    end

    // transmit bit engine
    if (tx_flush) begin
      next_s.tst   = TX_ABORT;             // see [RULE7]
      next_s.tsh   = {8'h00, ABORT_BYTE};
      next_s.tleft = BYTE_BITS;
      next_s.tones = 3'h0;
    end else if (tx_bit_strobe) begin
      if (tx_stuff) begin
        tb = 1'b0;                         // see [RULE3]
        next_s.tones = 3'h0;
      end else begin
        tb = s.tsh[0];
        next_s.tsh   = s.tsh >> 1;
        next_s.tleft = s.tleft - 5'h01;
        next_s.tones = tb ? ((s.tones == ONES_MAX) ? ONES_MAX
                                                   : s.tones + 3'h1) : 3'h0;
        if (s.tst == TX_DATA) begin
          next_s.tcrc = hdc_crc_bit(s.tcrc, tb);
        end
      end
      tx_fcs = ~next_s.tcrc ^ {16{s.ctrl[CTL_CRC_INV]}}; // see [RULE2]
      if (t_end) begin
        next_s.tleft = BYTE_BITS;
        unique case (s.tst)
          TX_FILL, TX_ABORT, TX_CLOSE: begin
            if (s.tst != TX_CLOSE && tx_count >= TX_MIN_BYTES) begin
              next_s.tst = TX_FLAG;
              next_s.tsh = {8'h00, FLAG_BYTE};
            end else begin
              next_s.tst = TX_FILL;        // see [RULE4]
              next_s.tsh = {8'h00, s.ctrl[CTL_FILL_SEL] ? IDLE_BYTE
                                                        : FLAG_BYTE};
            end
          end
          TX_FLAG, TX_DATA: begin
            if (s.tst == TX_DATA && s.tx_message_end_tag) begin
              if (s.ctrl[CTL_CRC_DEFEAT]) begin
                next_s.tst = TX_CLOSE;     // see [RULE1]
                next_s.tsh = {8'h00, FLAG_BYTE};
              end else begin
                next_s.tst   = TX_CRC;     // see [RULE1] see [RULE15]
                next_s.tsh   = tx_fcs;
                next_s.tleft = CRC_BITS;
              end
            end else if (s.tst == TX_DATA && tx_empty) begin
              ev[LAT_TUDR] = 1'b1;
              ev[LAT_TEND] = 1'b1;
              next_s.tst   = TX_ABORT;
              next_s.tsh   = {8'h00, ABORT_BYTE};
            end else begin
              tx_pop       = 1'b1;
              ev[LAT_TEND] = tx_rdata[8];
              next_s.tx_message_end_tag = tx_rdata[8];
              next_s.tst   = TX_DATA;
              next_s.tsh   = {8'h00, tx_rdata[7:0]};
              if (s.tst == TX_FLAG) begin
                next_s.tcrc = CRC_INIT;
              end
            end
          end
          TX_CRC: begin
            next_s.tst = TX_CLOSE;         // see [RULE15]
            next_s.tsh = {8'h00, FLAG_BYTE};
          end
        endcase
      end
      next_s.tbit = tb ^ s.ctrl[CTL_TX_INV]; // see [RULE5]
    end

    // receive bit engine
    if (rx_flush) begin
      next_s.rin   = 1'b0;                 // see [RULE8]
      next_s.rlock = 1'b0;
      next_s.rones = 3'h0;
    end else if (rx_bit_strobe) begin
      next_s.rones = rb ? ((s.rones == ONES_MAX) ? ONES_MAX
                                                 : s.rones + 3'h1) : 3'h0;
      if (~rb && s.rones == ONES_FLAG) begin
        // flag: close any packet, then restart the byte hunt
        if (s.rin && s.rheld != 2'h0) begin
          ev[LAT_RPE] = 1'b1;
          if (s.rheld == 2'h3 && ~s.rfirst) begin
            rx_do = 1'b1;                  // see [RULE14]
            rx_wdata = {(s.rbits != 3'h7) ? PS_BAD_LEN :
                        (s.rcrc != CRC_GOOD) ? PS_BAD_CRC : PS_GOOD,
                        1'b1, 1'b0, s.h0};
          end else if (s.rheld == 2'h3) begin
            rx_do = 1'b1;
            rx_wdata = {PS_BAD_LEN, 1'b1, 1'b1, s.h0};
          end
        end
        next_s.rin    = 1'b1;
        next_s.rfirst = 1'b1;
        next_s.rbits  = 3'h0;
        next_s.rheld  = 2'h0;
        next_s.rcrc   = CRC_INIT;
      end else if (rb && s.rones == ONES_FLAG) begin
        if (s.rin && (s.rheld != 2'h0 || s.rbits != 3'h0)) begin
          ev[LAT_RABT] = 1'b1;
          if (~s.rfirst) begin
            rx_do = 1'b1;
            rx_wdata = {PS_ABORT, 1'b1, 1'b0, 8'h00};
          end
        end
        next_s.rin = 1'b0;
      end else if (s.rin && !(~rb && s.rones == ONES_STUFF)) begin
        rbyte        = {rb, s.rsh[7:1]};
        next_s.rsh   = rbyte;
        next_s.rbits = s.rbits + 3'h1;
        if (s.rbits == 3'h7) begin
          next_s.rcrc = hdc_crc_byte(s.rcrc, rbyte);
          next_s.h0   = s.h1;
          next_s.h1   = s.h2;
          next_s.h2   = rbyte;
          if (s.rheld == 2'h3) begin
            rx_do = 1'b1;                  // see [RULE14]
            rx_wdata = {PS_GOOD, 1'b0, s.rfirst, s.h0};
            next_s.rfirst = 1'b0;
            ev[LAT_RPS] = s.rfirst;
          end else begin
            next_s.rheld = s.rheld + 2'h1;
          end
        end
      end
    end

    // overrun stops storage until the fifo drains or is reset
    if (rx_do && !s.rlock) begin
      if (rx_full) begin
        ev[LAT_ROVR] = 1'b1;
        next_s.rlock = 1'b1;
      end else begin
        rx_push = 1'b1;
      end
    end else if (s.rlock && rx_empty && !rx_flush) begin
      next_s.rlock = 1'b0;
    end

    // sticky flags: a new event beats a same-cycle clear
    next_s.tlow_d  = tx_low;
    next_s.rhigh_d = rx_high;
    ev[LAT_TX_BELOW_LOW_MARK] = tx_low & ~s.tlow_d;
    ev[LAT_RX_ABOVE_HIGH_MARK] = rx_high & ~s.rhigh_d;
    if (wr && paddr[11:2] == IDX_LATCHED) begin
      next_s.lat = (s.lat & ~pwdata[7:0]) | ev; // see [RULE13]
    end else begin
      next_s.lat = s.lat | ev;
    end
    next_s.irq = (|(next_s.lat & next_s.ie)) & next_s.blk_en; // see [RULE13]
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s       <= '0;
      s.ctrl  <= CTRL_RST_VAL;
      s.tst   <= TX_FILL;
      s.tsh   <= {8'h00, FLAG_BYTE};
      s.tleft <= BYTE_BITS;
      s.rcrc  <= CRC_INIT;
      s.tcrc  <= CRC_INIT;
    end else begin
      s <= next_s;
    end
  end

  assign prdata     = s.prdata;
  assign pready     = s.pready;
  assign pslverr    = s.pslverr;
  assign hdlc_irq   = s.irq;
  assign tx_bit_out = s.tbit;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_crc_defeat;
    (t_end && s.tst == TX_DATA && s.tx_message_end_tag && s.ctrl[CTL_CRC_DEFEAT])
      |=> (s.tst == TX_CLOSE && s.tsh[7:0] == FLAG_BYTE);
  endproperty
  a_crc_defeat: assert property (p_crc_defeat) // see [RULE1]
    else $error("crc not skipped under defeat");

  property p_crc_append;
    (t_end && s.tst == TX_DATA && s.tx_message_end_tag && !s.ctrl[CTL_CRC_DEFEAT])
      |=> (s.tst == TX_CRC && s.tleft == 5'h10 && s.tsh == $past(tx_fcs));
  endproperty
  a_crc_append: assert property (p_crc_append) // see [RULE2]
    else $error("crc not appended as expected");

  property p_stuff;
    (tx_bit_strobe && tx_stuff && !tx_flush)
      |=> (s.tbit == $past(s.ctrl[CTL_TX_INV]) && s.tones == 3'h0);
  endproperty
  a_stuff: assert property (p_stuff) // see [RULE3]
    else $error("stuffing zero missing");

  property p_fill;
    (t_end && s.tst == TX_CLOSE) |=> (s.tst == TX_FILL &&
      s.tsh[7:0] == ($past(s.ctrl[CTL_FILL_SEL]) ? IDLE_BYTE : FLAG_BYTE));
  endproperty
  a_fill: assert property (p_fill) // see [RULE4]
    else $error("wrong fill byte");

  property p_tx_inv;
    tx_step |=> (s.tbit == ($past(s.tsh[0]) ^ $past(s.ctrl[CTL_TX_INV])));
  endproperty
  a_tx_inv: assert property (p_tx_inv) // see [RULE5]
    else $error("transmit bit not inverted as set");

  property p_tx_rst;
    tx_flush |=> (s.tst == TX_ABORT && s.tsh[7:0] == ABORT_BYTE && tx_empty);
  endproperty
  a_tx_rst: assert property (p_tx_rst) // see [RULE7]
    else $error("transmit reset did not abort");

  property p_rx_rst;
    rx_flush |=> (!s.rin && rx_empty);
  endproperty
  a_rx_rst: assert property (p_rx_rst) // see [RULE8]
    else $error("receive reset did not flush");

  property p_tx_mark;
    (s.wmsel[2:0] == 3'h7) |-> (tx_low == (tx_count < 9'd240));
  endproperty
  a_tx_mark: assert property (p_tx_mark) // see [RULE10]
    else $error("tx low mark wrong at 240");

  property p_rx_mark;
    (s.wmsel[6:4] == 3'h0) |-> (rx_high == (rx_count > 9'd16));
  endproperty
  a_rx_mark: assert property (p_rx_mark) // see [RULE12]
    else $error("rx high mark wrong at 16");

  property p_sticky;
    (tx_low && !s.tlow_d) |=> s.lat[LAT_TX_BELOW_LOW_MARK];
  endproperty
  a_sticky: assert property (p_sticky) // see [RULE13]
    else $error("latched flag lost");

  property p_crc_held;
    rx_push |-> (s.rheld == 2'h3);
  endproperty
  a_crc_held: assert property (p_crc_held) // see [RULE14]
    else $error("crc byte stored");

  property p_close_flag;
    (t_end && s.tst == TX_CRC) |=> (s.tst == TX_CLOSE && s.tsh[7:0] == FLAG_BYTE);
  endproperty
  a_close_flag: assert property (p_close_flag) // see [RULE15]
    else $error("closing flag missing");

  c_packet_sent: cover property (t_end && s.tst == TX_CLOSE);
  c_rx_store:    cover property (rx_push && rx_wdata[9]);
  c_irq:         cover property (s.irq);
endmodule
`default_nettype wire

/* File: include/hdc_pkg.sv */
// Purpose: shared constants and types of the hdlc channel control block
// Assumes: one 25 MHz core clock, apb register access
// Notes:   register indices are word indices; byte address is index * 4
package hdc_pkg;
  localparam int APB_AW     = 12;
  localparam int APB_DW     = 32;
  localparam int FIFO_DEPTH = 256;
  localparam int FIFO_AW    = 8;
  localparam int TX_W       = 9;
  localparam int RX_W       = 12;

  // register word indices
  localparam logic [9:0] IDX_CTRL_ONE = 10'h050;
  localparam logic [9:0] IDX_WM_SEL   = 10'h051;
  localparam logic [9:0] IDX_LIVE     = 10'h054;
  localparam logic [9:0] IDX_LATCHED  = 10'h055;
  localparam logic [9:0] IDX_IRQ_EN   = 10'h056;
  localparam logic [9:0] IDX_INFO     = 10'h057;
  localparam logic [9:0] IDX_BLK_EN   = 10'h058;
  localparam logic [9:0] IDX_RX_DATA  = 10'h05c;
  localparam logic [9:0] IDX_RX_TAG   = 10'h05d;
  localparam logic [9:0] IDX_TX_DATA  = 10'h05e;
  localparam logic [9:0] IDX_TX_TAG   = 10'h05f;

  // control one fields
  localparam int CTL_CRC_DEFEAT = 0;
  localparam int CTL_CRC_INV    = 1;
  localparam int CTL_ZS_DEFEAT  = 2;
  localparam int CTL_FILL_SEL   = 3;
  localparam int CTL_TX_INV     = 4;
  localparam int CTL_RX_INV     = 5;
  localparam int CTL_TX_RST     = 6;
  localparam int CTL_RX_RST     = 7;
  localparam logic [7:0] CTRL_RST_VAL = 8'h00;
  localparam logic [7:0] WM_MASK      = 8'h77;

  // latched status and live status fields
  localparam int LAT_TEND = 0;
  localparam int LAT_TUDR = 1;
  localparam int LAT_TX_BELOW_LOW_MARK = 2;
  localparam int LAT_RX_ABOVE_HIGH_MARK = 3;
  localparam int LAT_RABT = 4;
  localparam int LAT_RPS  = 5;
  localparam int LAT_RPE  = 6;
  localparam int LAT_ROVR = 7;
  localparam int LIVE_TLOW   = 2;
  localparam int LIVE_RHIGH  = 3;
  localparam int INFO_TX_FIFO_EMPTY = 4;
  localparam int INFO_RX_FIFO_EMPTY = 5;

  // line bytes, crc and packet status codes
  localparam logic [7:0]  FLAG_BYTE  = 8'h7e;
  localparam logic [7:0]  IDLE_BYTE  = 8'hff;
  localparam logic [7:0]  ABORT_BYTE = 8'hfe;
  localparam logic [15:0] CRC_POLY   = 16'h8408;
  localparam logic [15:0] CRC_INIT   = 16'hffff;
  localparam logic [15:0] CRC_GOOD   = 16'hf0b8;
  localparam logic [1:0]  PS_GOOD    = 2'h0;
  localparam logic [1:0]  PS_BAD_CRC = 2'h1;
  localparam logic [1:0]  PS_ABORT   = 2'h2;
  localparam logic [1:0]  PS_BAD_LEN = 2'h3;
  localparam logic [8:0]  WM_BASE    = 9'h010;
  localparam logic [8:0]  TX_MIN_BYTES = 9'h002;
  localparam logic [2:0]  ONES_STUFF = 3'h5;
  localparam logic [2:0]  ONES_FLAG  = 3'h6;
  localparam logic [2:0]  ONES_MAX   = 3'h7;
  localparam logic [4:0]  BYTE_BITS  = 5'h08;
  localparam logic [4:0]  CRC_BITS   = 5'h10;

  typedef enum logic [5:0] {
    TX_FILL  = 6'b00_0001,
    TX_ABORT = 6'b00_0010,
    TX_FLAG  = 6'b00_0100,
    TX_DATA  = 6'b00_1000,
    TX_CRC   = 6'b01_0000,
    TX_CLOSE = 6'b10_0000
  } hdc_tx_state_t;

  // crc-16 over one bit, lsb first
  function automatic logic [15:0] hdc_crc_bit(logic [15:0] c, logic b);
    hdc_crc_bit = (c >> 1) ^ ((c[0] ^ b) ? CRC_POLY : 16'h0000);
  endfunction

  function automatic logic [15:0] hdc_crc_byte(logic [15:0] c,
                                               logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = hdc_crc_bit(r, d[i]);
    end
    hdc_crc_byte = r;
  endfunction

  // watermark threshold 16 + 32 * code
  function automatic logic [8:0] hdc_thr(logic [2:0] sel);
    hdc_thr = {1'b0, sel, 5'h00} + WM_BASE;
  endfunction
endpackage

/* File: design/hdc_fifo.sv */
// Purpose: byte fifo with show-ahead read and synchronous flush
// Assumes: push ignored when full, pop ignored when empty
// Notes:   count is one bit wider than the address
`timescale 1ns/100ps
`default_nettype none
module hdc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  input  wire logic          flush,
  input  wire logic          push,
  input  wire logic [W-1:0]  wdata,
  input  wire logic          pop,
  output logic      [W-1:0]  rdata,
  output logic      [AW:0]   count,
  output logic               empty,
  output logic               full
);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } hdc_fifo_st_t;

  hdc_fifo_st_t s;
  hdc_fifo_st_t next_s;
  logic [W-1:0] mem [DEPTH];
  logic         do_push;
  logic         do_pop;

  // guarded strobes and pointer update
  always_comb begin
    do_push = push & ~full & ~flush;
    do_pop  = pop & ~empty & ~flush;
    next_s  = s;
    if (flush) begin
      next_s = '0;
    end else begin
      next_s.wp  = s.wp + AW'(do_push);
      next_s.rp  = s.rp + AW'(do_pop);
      next_s.cnt = s.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // storage has no reset
  always_ff @(posedge core_clk) begin
    if (do_push) begin
      mem[s.wp] <= wdata;
    end
  end

  assign rdata = mem[s.rp];
  assign count = s.cnt;
  assign empty = (s.cnt == '0);
  assign full  = (s.cnt == (AW+1)'(DEPTH));
endmodule
`default_nettype wire

/* File: verif/hdc_framer_model.sv */
// Purpose: framer overhead slot model for the hdlc channel
// Assumes: one bit slot per clock while run is high
// Notes:   rx line is the tx line looped back; last tx byte kept lsb first
`timescale 1ns/100ps
`default_nettype none
module hdc_framer_model (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       run,
  input  wire logic       tx_bit_out,
  output logic            tx_bit_strobe,
  output logic            rx_bit_strobe,
  output logic            rx_bit_in,
  output logic      [7:0] line_byte
);
  logic seen;
  // slots are offered only while the bench asks for them
  assign tx_bit_strobe = run;
  assign rx_bit_strobe = run;
  assign rx_bit_in     = tx_bit_out;
  // take each sent bit one cycle after its slot
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      seen      <= 1'b0;
      line_byte <= 8'h00;
    end else begin
      seen <= tx_bit_strobe;
      if (seen) begin
        line_byte <= {tx_bit_out, line_byte[7:1]};
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/test_hdlc_channel_control.sv */
// Purpose: register level test of the hdlc channel control block
// Assumes: apb slave answers by pready, waits are bounded
// Notes:   transmit line watched through the framer slot model
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
  err_count++; $display("unexpected at %0t got %h exp %h", $time, g, e); \
  end end
module test_hdlc_channel_control;
  import hdc_pkg::*;
  logic              core_clk, sys_rst, psel, penable, pwrite, run;
  logic              pready, pslverr, hdlc_irq, slv;
  logic              tx_bit_strobe, tx_bit_out, rx_bit_strobe, rx_bit_in;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata, prdata, rd;
  logic [7:0]        line_byte;
  int                err_count, num_checks;

  hdc_channel dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hdlc_irq(hdlc_irq), .tx_bit_strobe(tx_bit_strobe),
    .tx_bit_out(tx_bit_out), .rx_bit_strobe(rx_bit_strobe),
    .rx_bit_in(rx_bit_in));
  hdc_framer_model far_u (.core_clk(core_clk), .sys_rst(sys_rst), .run(run),
    .tx_bit_out(tx_bit_out), .tx_bit_strobe(tx_bit_strobe),
    .rx_bit_strobe(rx_bit_strobe), .rx_bit_in(rx_bit_in),
    .line_byte(line_byte));

  // 40 ns core clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic finish_test();
    if (err_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [9:0] idx,
                     input logic [7:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rdc(input logic [9:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    `CHK(rd, {24'h00_0000, e})
  endtask

  // interrupt output is registered, let it settle first
  task automatic irq_is(input logic e);
    repeat (2) @(posedge core_clk);
    `CHK(hdlc_irq, e)
  endtask

  initial begin
    repeat (5000) @(posedge core_clk);
    err_count++;
    finish_test();
  end

  // main sequence
  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, run} = 4'h0;
    paddr  = '0;
    pwdata = '0;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rdc(IDX_CTRL_ONE, CTRL_RST_VAL);
    apb(1'b0, 10'h052, 8'h00);
    `CHK(slv, 1'b1)
    rdc(IDX_INFO, 8'h30);
    for (int i = 0; i < 15; i++) begin
      apb(1'b1, IDX_TX_DATA, i[7:0]);
    end
    rdc(IDX_LIVE, 8'h04);
    apb(1'b1, IDX_TX_DATA, 8'h0f);
    rdc(IDX_INFO, 8'h21);
    // 16 bytes sit at the 000 threshold and below all others
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, IDX_WM_SEL, {1'b0, c[2:0], 1'b0, c[2:0]});
      rdc(IDX_LIVE, (c == 0) ? 8'h00 : 8'h04);
    end
    apb(1'b1, IDX_WM_SEL, 8'h00);
    apb(1'b1, IDX_LATCHED, 8'hff);
    apb(1'b1, IDX_IRQ_EN, 8'h04);
    apb(1'b1, IDX_BLK_EN, 8'h01);
    irq_is(1'b0);
    apb(1'b1, IDX_CTRL_ONE, 8'h40);
    rdc(IDX_INFO, 8'h30);
    rdc(IDX_LATCHED, 8'h04);
    irq_is(1'b1);
    apb(1'b1, IDX_BLK_EN, 8'h00);
    irq_is(1'b0);
    apb(1'b1, IDX_BLK_EN, 8'h01);
    apb(1'b1, IDX_LATCHED, 8'h04);
    irq_is(1'b0);
    rdc(IDX_LATCHED, 8'h00);
    apb(1'b1, IDX_TX_DATA, 8'h55);
    apb(1'b1, IDX_TX_DATA, 8'haa);
    apb(1'b1, IDX_CTRL_ONE, 8'h40);
    rdc(IDX_INFO, 8'h20);
    apb(1'b1, IDX_CTRL_ONE, 8'h00);
    apb(1'b1, IDX_CTRL_ONE, 8'h40);
    rdc(IDX_INFO, 8'h30);
    // one tagged packet looped back; ffh forces a stuffed zero
    apb(1'b1, IDX_CTRL_ONE, 8'h00);
    apb(1'b1, IDX_TX_DATA, 8'hff);
    apb(1'b1, IDX_TX_TAG, 8'h01);
    apb(1'b1, IDX_TX_DATA, 8'haa);
    run <= 1'b1;
    repeat (100) @(posedge core_clk);
    rdc(IDX_RX_TAG, 8'h01);
    rdc(IDX_RX_DATA, 8'hff);
    rdc(IDX_RX_TAG, 8'h02);
    rdc(IDX_LATCHED, 8'h61);
    apb(1'b1, IDX_CTRL_ONE, 8'h80);
    rdc(IDX_INFO, 8'h30);
    apb(1'b1, IDX_CTRL_ONE, 8'h08);
    run <= 1'b1;
    repeat (40) @(posedge core_clk);
    `CHK(line_byte, IDLE_BYTE)
    apb(1'b1, IDX_CTRL_ONE, 8'h18);
    repeat (40) @(posedge core_clk);
    `CHK(line_byte, ~IDLE_BYTE)
    finish_test();
  end
endmodule
`default_nettype wire
